//--- hslp_top.sv
// host serial link port: equipment-end asynchronous serial link
// assumes line pins are asynchronous; characters enter and leave by valid/ready
//
// Summary of operation
// - act as communication equipment: receive on transmit-data pin, send on receive-data
// - received characters: one start, eight data, one or more stop bits
// - top data bit is a parity position, not character content
// - transmitter always sends the top data bit as zero
// - receiver ignores the top data bit of incoming characters
// - works with no modem control activity from the host
// - host request-to-send returned unchanged as clear-to-send
// - data-set-ready and carrier-detect held high while powered
`timescale 1ns/1ns
module hslp_top (
    // clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RST,
    // serial pins
    input  wire logic       TXD_IN,
    output logic            RXD_OUT,
    input  wire logic       RTS_IN,
    output logic            CTS_OUT,
    output logic            DSR_OUT,
    output logic            DCD_OUT,
    // transmit characters
    input  wire logic       TX_VALID,
    output logic            TX_READY,
    input  wire logic [7:0] TX_DATA,
    // received characters
    output logic            RX_VALID,
    input  wire logic       RX_READY,
    output logic      [7:0] RX_DATA,
    output logic            RX_FRAME_ERROR
);
    // ****************************************
    // declarations
    // ****************************************
    localparam int BIT_CLOCKS   = hslp_pkg::TICK_CYCLES * hslp_pkg::OVERSAMPLE;
    // one start bit ahead of the data and stop bits
    localparam int FRAME_CLOCKS = (1 + hslp_pkg::DATA_BITS + hslp_pkg::TX_STOP_BITS) * BIT_CLOCKS;
    localparam int RUN_W        = $clog2(BIT_CLOCKS + 1);
    localparam int FRAME_W      = $clog2(FRAME_CLOCKS + 1);
    logic [hslp_pkg::TICK_W-1:0] tick_cnt;
    logic       tick;
    logic       txd_meta;
    logic       txd_sync;
    logic       rts_meta;
    logic       rts_sync;
    logic       rx_char_valid;
    logic [7:0] rx_char_data;
    logic       rx_frame_err;
    logic       rx_fifo_ready;
    logic       rx_fifo_valid;
    logic [7:0] rx_fifo_data;
    logic       tx_fifo_ready;
    logic       tx_fifo_valid;
    logic [7:0] tx_fifo_data;
    logic       tx_take;
    hslp_pkg::hslp_state_t tx_state;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic [7:0] tx_shift;
    logic               rxd_prev;
    logic [RUN_W-1:0]   rxd_run;
    logic [FRAME_W-1:0] tx_frame_cnt;

    // ****************************************
    // oversample tick, 16 per bit
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick     <= (tick_cnt == hslp_pkg::TICK_LAST);
            tick_cnt <= (tick_cnt == hslp_pkg::TICK_LAST) ? '0 : tick_cnt + 1'b1;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            txd_meta <= hslp_pkg::LINE_IDLE;
            txd_sync <= hslp_pkg::LINE_IDLE;
            rts_meta <= 1'b0;
            rts_sync <= 1'b0;
        end else begin
            txd_meta <= TXD_IN;
            txd_sync <= txd_meta;
            rts_meta <= RTS_IN;
            rts_sync <= rts_meta;
        end
    end

    // ****************************************
    // modem status lines
    // ****************************************
    // nothing below waits on rts or dtr, so a three-wire cable suffices
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CTS_OUT <= 1'b0;
            DSR_OUT <= 1'b1;
            DCD_OUT <= 1'b1;
        end else begin
            CTS_OUT <= rts_sync;
            DSR_OUT <= 1'b1;
            DCD_OUT <= 1'b1;
        end
    end

    // ****************************************
    // receive path
    // ****************************************
    hslp_rx u_rx (
        .clk         (CLOCK),
        .rst         (RST),
        .line_in     (txd_sync),
        .tick        (tick),
        .char_valid  (rx_char_valid),
        .char_data   (rx_char_data),
        .frame_error (rx_frame_err)
    );

    // no handshake on the line: a char arriving at a full fifo is lost
    hslp_fifo #(
        .WIDTH (hslp_pkg::DATA_BITS),
        .DEPTH (hslp_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (CLOCK),
        .rst       (RST),
        .in_valid  (rx_char_valid),
        .in_ready  (rx_fifo_ready),
        .in_data   (rx_char_data),
        .out_valid (rx_fifo_valid),
        .out_ready (RX_READY && RX_VALID),
        .out_data  (rx_fifo_data)
    );

    // output register mirrors the fifo head; the head pops as it is taken
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RX_VALID       <= 1'b0;
            RX_DATA        <= '0;
            RX_FRAME_ERROR <= 1'b0;
        end else begin
            RX_FRAME_ERROR <= rx_frame_err;
            if (RX_VALID && RX_READY) begin
                RX_VALID <= 1'b0;
            end else if (!RX_VALID && rx_fifo_valid) begin
                RX_VALID <= 1'b1;
                RX_DATA  <= rx_fifo_data;
            end
        end
    end

    // ****************************************
    // transmit path
    // ****************************************
    hslp_fifo #(
        .WIDTH (hslp_pkg::DATA_BITS),
        .DEPTH (hslp_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (CLOCK),
        .rst       (RST),
        .in_valid  (TX_VALID && TX_READY),
        .in_ready  (tx_fifo_ready),
        .in_data   (TX_DATA),
        .out_valid (tx_fifo_valid),
        .out_ready (tx_take),
        .out_data  (tx_fifo_data)
    );

    // ready is registered, so it lags the fifo by one cycle; it only drops early
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            TX_READY <= 1'b0;
        end else begin
            TX_READY <= tx_fifo_ready && !(TX_VALID && TX_READY);
        end
    end

    assign tx_take = tick && (tx_state == hslp_pkg::HSLP_IDLE) && tx_fifo_valid;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tx_state <= hslp_pkg::HSLP_IDLE;
            tx_os    <= '0;
            tx_bit   <= '0;
            tx_shift <= '0;
            RXD_OUT  <= hslp_pkg::LINE_IDLE;
        end else if (tick) begin
            case (tx_state)
                hslp_pkg::HSLP_IDLE: begin
                    RXD_OUT <= hslp_pkg::LINE_IDLE;
                    tx_os   <= '0;
                    if (tx_fifo_valid) begin
                        // parity slot forced low on every outgoing char
                        tx_shift <= {1'b0, tx_fifo_data[6:0]};
                        RXD_OUT  <= hslp_pkg::LINE_START;
                        tx_state <= hslp_pkg::HSLP_START;
                    end
                end
                hslp_pkg::HSLP_START: begin
                    tx_os <= tx_os + 1'b1;
                    if (tx_os == hslp_pkg::OS_LAST) begin
                        RXD_OUT  <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit   <= '0;
                        tx_state <= hslp_pkg::HSLP_DATA;
                    end
                end
                hslp_pkg::HSLP_DATA: begin
                    tx_os <= tx_os + 1'b1;
                    if (tx_os == hslp_pkg::OS_LAST) begin
                        tx_bit <= tx_bit + 1'b1;
                        if (tx_bit == hslp_pkg::BIT_LAST) begin
                            RXD_OUT  <= hslp_pkg::LINE_IDLE;
                            tx_bit   <= '0;
                            tx_state <= hslp_pkg::HSLP_STOP;
                        end else begin
                            RXD_OUT  <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                        end
                    end
                end
                hslp_pkg::HSLP_STOP: begin
                    tx_os <= tx_os + 1'b1;
                    if (tx_os == hslp_pkg::OS_LAST) begin
                        tx_bit <= tx_bit + 1'b1;
                        if (tx_bit == hslp_pkg::STOP_LAST) begin
                            tx_state <= hslp_pkg::HSLP_IDLE;
                        end
                    end
                end
                default: tx_state <= hslp_pkg::HSLP_IDLE;
            endcase
        end
    end

    // ****************************************
    // line timing monitors
    // ****************************************
    // run starts saturated so the first start bit after reset is not short
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rxd_prev <= hslp_pkg::LINE_IDLE;
            rxd_run  <= '1;
        end else begin
            rxd_prev <= RXD_OUT;
            if (RXD_OUT != rxd_prev) begin
                rxd_run <= RUN_W'(1);
            end else if (rxd_run != '1) begin
                rxd_run <= rxd_run + 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            tx_frame_cnt <= '0;
        end else if (tx_state == hslp_pkg::HSLP_IDLE) begin
            tx_frame_cnt <= '0;
        end else begin
            tx_frame_cnt <= tx_frame_cnt + 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_CTS_FOLLOWS_RTS: assert property (@(posedge CLOCK) disable iff (RST)
        CTS_OUT == $past(rts_sync))
        else $error("cts does not follow rts");
    AST_DSR_HIGH: assert property (@(posedge CLOCK) disable iff (RST)
        DSR_OUT && DCD_OUT)
        else $error("dsr or dcd dropped");
    AST_TX_STOP_HIGH: assert property (@(posedge CLOCK) disable iff (RST)
        (tx_state == hslp_pkg::HSLP_STOP) |-> RXD_OUT)
        else $error("stop bit not high");
    AST_TX_START_LOW: assert property (@(posedge CLOCK) disable iff (RST)
        (tx_state == hslp_pkg::HSLP_START) |-> !RXD_OUT)
        else $error("start bit not low");
    AST_TX_TOP_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
        (tx_state == hslp_pkg::HSLP_DATA) |-> !tx_shift[hslp_pkg::PARITY_POS])
        else $error("top data bit not zero");
    AST_TX_IDLE_HIGH: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(tx_state == hslp_pkg::HSLP_IDLE) |-> RXD_OUT)
        else $error("line not idle after frame");
    AST_TICK_PERIOD: assert property (@(posedge CLOCK) disable iff (RST)
        tick |=> !tick [*8])
        else $error("tick too frequent");
    AST_RX_OUT_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        (RX_VALID && !RX_READY) |=> (RX_VALID && $stable(RX_DATA)))
        else $error("rx output dropped before taken");
    AST_TX_LEVEL_MIN_BIT: assert property (@(posedge CLOCK) disable iff (RST)
        (RXD_OUT != rxd_prev) |-> (rxd_run >= RUN_W'(BIT_CLOCKS)))
        else $error("line level shorter than one bit");
    AST_TX_FRAME_LENGTH: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(tx_state == hslp_pkg::HSLP_IDLE) |-> (tx_frame_cnt == FRAME_W'(FRAME_CLOCKS)))
        else $error("frame length not eleven bits");
endmodule : hslp_top

//--- hslp_pkg.sv
// constants for the host serial link port: framing, bit timing, fifo shape
// assumes a 100 MHz core clock and a fixed 9600 baud line
package hslp_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_HZ      = 100000000;
    localparam int BAUD_RATE     = 9600;
    localparam int OVERSAMPLE    = 16;
    // sample tick period in core clocks, rounded down
    localparam int TICK_CYCLES   = CLOCK_HZ / (BAUD_RATE * OVERSAMPLE);
    localparam int TICK_W        = 10;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] OS_MID  = 4'h7;
    // ****************************************
    // framing
    // ****************************************
    localparam int DATA_BITS     = 8;
    localparam int TX_STOP_BITS  = 2;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] STOP_LAST = 4'(TX_STOP_BITS - 1);
    localparam int PARITY_POS    = 7;
    localparam int FIFO_DEPTH    = 8;
    localparam logic LINE_IDLE   = 1'b1;
    localparam logic LINE_START  = 1'b0;
    typedef enum logic [1:0] {
        HSLP_IDLE  = 2'b00,
        HSLP_START = 2'b01,
        HSLP_DATA  = 2'b10,
        HSLP_STOP  = 2'b11
    } hslp_state_t;
endpackage : hslp_pkg

//--- hslp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/1ns
module hslp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ****************************************
    // storage and pointers
    // ****************************************
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : hslp_fifo

//--- hslp_rx.sv
// serial receiver: oversampled, centre sampled, stop bit checked
// assumes the line input is already synchronised to clk
`timescale 1ns/1ns
module hslp_rx (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // line
    input  wire logic       line_in,
    input  wire logic       tick,
    // character out
    output logic            char_valid,
    output logic      [7:0] char_data,
    output logic            frame_error
);
    hslp_pkg::hslp_state_t state;
    logic [3:0] os_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shift;

    // ****************************************
    // receive sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= hslp_pkg::HSLP_IDLE;
            os_cnt      <= '0;
            bit_cnt     <= '0;
            shift       <= '0;
            char_valid  <= 1'b0;
            char_data   <= '0;
            frame_error <= 1'b0;
        end else begin
            char_valid  <= 1'b0;
            frame_error <= 1'b0;
            if (tick) begin
                case (state)
                    hslp_pkg::HSLP_IDLE: begin
                        os_cnt <= '0;
                        if (line_in == hslp_pkg::LINE_START) begin
                            state <= hslp_pkg::HSLP_START;
                        end
                    end
                    hslp_pkg::HSLP_START: begin
                        // recheck at mid bit to reject glitches
                        if (os_cnt == hslp_pkg::OS_MID) begin
                            os_cnt  <= '0;
                            bit_cnt <= '0;
                            state   <= (line_in == hslp_pkg::LINE_START) ?
                                       hslp_pkg::HSLP_DATA : hslp_pkg::HSLP_IDLE;
                        end else begin
                            os_cnt <= os_cnt + 1'b1;
                        end
                    end
                    hslp_pkg::HSLP_DATA: begin
                        os_cnt <= os_cnt + 1'b1;
                        if (os_cnt == hslp_pkg::OS_LAST) begin
                            shift <= {line_in, shift[7:1]};
                            bit_cnt <= bit_cnt + 1'b1;
                            if (bit_cnt == hslp_pkg::BIT_LAST) begin
                                state <= hslp_pkg::HSLP_STOP;
                            end
                        end
                    end
                    hslp_pkg::HSLP_STOP: begin
                        os_cnt <= os_cnt + 1'b1;
                        if (os_cnt == hslp_pkg::OS_LAST) begin
                            // only one stop bit is checked; extra ones look idle
                            state <= hslp_pkg::HSLP_IDLE;
                            if (line_in == hslp_pkg::LINE_IDLE) begin
                                char_valid <= 1'b1;
                                // top bit is a parity slot, cleared on intake
                                char_data <= {1'b0, shift[6:0]};
                            end else begin
                                frame_error <= 1'b1;
                            end
                        end
                    end
                    default: state <= hslp_pkg::HSLP_IDLE;
                endcase
            end
        end
    end

    AST_RX_BIT7_CLEAR: assert property (@(posedge clk) disable iff (rst)
        char_valid |-> !char_data[hslp_pkg::PARITY_POS])
        else $error("received char has top bit set");
    AST_RX_NO_BOTH: assert property (@(posedge clk) disable iff (rst)
        !(char_valid && frame_error))
        else $error("char accepted with bad stop bit");
    AST_RX_STOP_SEEN: assert property (@(posedge clk) disable iff (rst)
        char_valid |-> ($past(line_in) == hslp_pkg::LINE_IDLE))
        else $error("char accepted without high stop bit");
endmodule : hslp_rx

//--- hslp_host_model.sv
// host-side serial model: drives the host data line, decodes the device line
// assumes a 100 MHz bench clock and a 9600 baud link with no handshake
`timescale 1ns/1ns
module hslp_host_model #(
    parameter int BIT_CYCLES = 10416
) (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      txd,
    input  wire logic rxd,
    output logic      rts
);
    // ****************************************
    // host side of the link
    // ****************************************
    initial begin
        txd = 1'b1;
        rts = 1'b0;
    end

    task automatic set_rts(input logic v);
        rts = v;
    endtask : set_rts

    task automatic hold_bit(input logic v);
        txd = v;
        repeat (BIT_CYCLES) @(negedge clk);
    endtask : hold_bit

    // a low stop bit is a framing fault made on purpose
    task automatic send_char(input logic [7:0] d, input int nstop, input bit bad_stop);
        @(negedge clk);
        hold_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            hold_bit(d[i]);
        end
        for (int i = 0; i < nstop; i++) begin
            hold_bit(~bad_stop);
        end
        txd = 1'b1;
    endtask : send_char

    // samples mid-bit; gives up when no start edge shows within bound
    task automatic recv_char(input int bound, output logic [7:0] d, output logic [1:0] stop,
                             output bit ok);
        int i;
        ok = 1'b0;
        d = 8'h00;
        stop = 2'h0;
        for (i = 0; i < bound && rxd !== 1'b0; i++) begin
            @(negedge clk);
        end
        if (rxd !== 1'b0) return;
        repeat (BIT_CYCLES / 2) @(negedge clk);
        if (rxd !== 1'b0) return;
        for (i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(negedge clk);
            d[i] = rxd;
        end
        for (i = 0; i < 2; i++) begin
            repeat (BIT_CYCLES) @(negedge clk);
            stop[i] = rxd;
        end
        ok = 1'b1;
    endtask : recv_char
endmodule : hslp_host_model

//--- hslp_top_tb_top.sv
// self-checking bench for the host serial link port
// assumes the host model file and the design files are compiled first
`timescale 1ns/1ns
module hslp_top_tb_top;
    localparam int BIT = 10416;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       txd;
    logic       rxd_out;
    logic       rts;
    logic       cts;
    logic       dsr;
    logic       dcd;
    logic       tx_valid = 1'b0;
    logic       tx_ready;
    logic [7:0] tx_data = 8'h00;
    logic       rx_valid;
    logic       rx_ready = 1'b0;
    logic [7:0] rx_data;
    logic       rx_frame_error;
    int         error_cnt = 0;
    int         checks = 0;

    always #5 clock = ~clock;

    hslp_top dut (
        .CLOCK(clock), .RST(rst), .TXD_IN(txd), .RXD_OUT(rxd_out), .RTS_IN(rts),
        .CTS_OUT(cts), .DSR_OUT(dsr), .DCD_OUT(dcd), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .RX_DATA(rx_data), .RX_FRAME_ERROR(rx_frame_error)
    );
    hslp_host_model #(.BIT_CYCLES(BIT)) host (.clk(clock), .txd(txd), .rxd(rxd_out), .rts(rts));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic summarize();
        $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic timeout(input string what);
        error_cnt++;
        $display("mismatch %s expected done seen timeout", what);
        summarize();
    endtask : timeout

    // ****************************************
    // drivers
    // ****************************************
    // ready only moves on rising edges, so the falling-edge value is what gets sampled
    task automatic push(input logic [7:0] d, input int bound, output bit ok);
        ok = 1'b0;
        @(negedge clock);
        tx_valid = 1'b1;
        tx_data = d;
        for (int i = 0; i < bound && !ok; i++) begin
            if (tx_ready === 1'b1) ok = 1'b1;
            @(negedge clock);
        end
        tx_valid = 1'b0;
    endtask : push

    task automatic rx_take(input logic [7:0] exp, input int bound);
        for (int i = 0; i < bound && rx_valid !== 1'b1; i++) begin
            @(negedge clock);
        end
        if (rx_valid !== 1'b1) timeout("rx char");
        repeat (3) @(negedge clock);
        cmp_bit("rx valid held", 1'b1, rx_valid);
        cmp_byte("rx data", exp, rx_data);
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
        cmp_bit("rx valid after take", 1'b0, rx_valid);
    endtask : rx_take

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        @(negedge clock);
        rst = 1'b1;
        repeat (20) @(negedge clock);
        cmp_bit("line idle", 1'b1, rxd_out);
        cmp_bit("dsr", 1'b1, dsr);
        cmp_bit("dcd", 1'b1, dcd);
        cmp_bit("cts in reset", 1'b0, cts);
        cmp_bit("tx ready in reset", 1'b0, tx_ready);
        cmp_bit("rx valid in reset", 1'b0, rx_valid);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        cmp_bit("tx ready after reset", 1'b1, tx_ready);
        $display("test reset done");
    endtask : test_reset

    task automatic test_cts();
        logic v;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0);
            @(negedge clock);
            host.set_rts(v);
            repeat (2) @(negedge clock);
            cmp_bit("cts before echo", ~v, cts);
            @(negedge clock);
            cmp_bit("cts echo", v, cts);
        end
        $display("test cts done");
    endtask : test_cts

    // both directions at once, host handshake lines left idle
    task automatic test_duplex();
        logic [7:0] d;
        logic [1:0] s;
        bit         ok;
        fork
            begin
                push(8'hc1, 8, ok);
                if (!ok) timeout("tx take");
                host.recv_char(2 * BIT, d, s, ok);
                if (!ok) timeout("tx frame");
                cmp_byte("line char", 8'h41, d);
                cmp_byte("stop bits", 8'h03, {6'h00, s});
            end
            begin
                host.send_char(8'hd5, 1, 1'b0);
                host.send_char(8'h33, 1, 1'b0);
            end
            begin
                rx_take(8'h55, 12 * BIT);
                rx_take(8'h33, 12 * BIT);
            end
        join
        cmp_bit("dsr in traffic", 1'b1, dsr);
        cmp_bit("dcd in traffic", 1'b1, dcd);
        $display("test duplex done");
    endtask : test_duplex

    task automatic test_frame();
        int fe;
        int vals;
        fe = 0;
        vals = 0;
        fork
            host.send_char(8'h00, 1, 1'b1);
            for (int i = 0; i < 11 * BIT; i++) begin
                @(negedge clock);
                fe += (rx_frame_error === 1'b1);
                vals += (rx_valid === 1'b1);
            end
        join
        cmp_byte("frame error pulses", 8'h01, 8'(fe));
        cmp_byte("dropped char", 8'h00, 8'(vals));
        fork
            host.send_char(8'h7e, 2, 1'b0);
            rx_take(8'h7e, 12 * BIT);
        join
        $display("test frame done");
    endtask : test_frame

    // fill the send buffer until refused; the line lets at most one char drain from it meanwhile
    task automatic test_fill();
        int n;
        bit ok;
        n = 0;
        ok = 1'b1;
        while (ok && n < 12) begin
            push(8'(8'h30 + n), 4, ok);
            if (ok) n++;
        end
        cmp_bit("buffer refused", 1'b0, tx_ready);
        cmp_bit("accepted count", 1'b1, n == 8 || n == 9);
        $display("test fill done");
    endtask : test_fill

    initial begin
        test_reset();
        test_cts();
        test_duplex();
        test_frame();
        test_fill();
        test_reset();
        summarize();
    end
endmodule : hslp_top_tb_top
